// File: src/fast_detect_defs.svh
`ifndef FAST_DETECT_DEFS_SVH
`define FAST_DETECT_DEFS_SVH

// register addresses on the internal control-port bus
`define ADDR_W 13
`define ADDR_OUTPUT_MODE 13'h014
`define ADDR_FD_CONTROL 13'h104
`define ADDR_UPPER_LOW 13'h106
`define ADDR_UPPER_HIGH 13'h107
`define ADDR_LOWER_LOW 13'h108
`define ADDR_LOWER_HIGH 13'h109

// field positions
`define FD_MODE_LSB 1
`define FD_MODE_MSB 3
`define OUTPUT_DISABLE_BIT 4
`define THRESH_HIGH_BITS 5

// reset values
`define FD_MODE_RESET 3'h0
`define UPPER_RESET 13'h1FFF
`define LOWER_RESET 13'h0000
`define OUTPUT_DISABLE_RESET 1'h0

// latency in sample clock cycles, counted from the input to the output pins
`define FAST_LATENCY 2
`define SUBSET_LATENCY 6

// magnitude and coarse level limits
`define MAG_MAX 13'h1FFF
`define COARSE_SUBSET_MAX 4'h7

`endif

// File: src/fast_detect_pkg.sv
package fast_detect_pkg;

	typedef enum logic [2:0] {
		MODE_MAG4,
		MODE_MAG3_OVR,
		MODE_MAG2_OVR_LOWER,
		MODE_MAG2_LOWER,
		MODE_OVR_UPPER_LOWER,
		MODE_OVR_UPPER,
		MODE_SPARE6,
		MODE_SPARE7
	} fd_mode_t;

	// one channel's view of the converter data path
	typedef struct packed {
		logic [3:0] coarseLevel;
		logic [13:0] sample;
		logic pipeOverflow;
	} sample_in_t;

	typedef struct packed {
		logic [12:0] upper;
		logic [12:0] lower;
	} thresholds_t;

	typedef struct packed {
		logic [3:0] mag4;
		logic [2:0] mag3;
		logic overrangeFlag;
		logic fineUpperFlag;
		logic fineLowerFlag;
	} chan_flags_t;

endpackage : fast_detect_pkg

// File: src/delay_line.sv
module delay_line #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage [DEPTH];
	logic [WIDTH-1:0] next_stage [DEPTH];

	always_comb
	begin
		next_stage[0] = din;
		for (int i = 1; i < DEPTH; i++)
		begin
			next_stage[i] = stage[i-1];
		end
	end

	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (rst)
				stage[i] <= '0;
			else
				stage[i] <= next_stage[i];
		end
	end

	assign dout = stage[DEPTH-1];

endmodule : delay_line

// File: src/fast_detect_channel.sv
`include "fast_detect_defs.svh"

module fast_detect_channel (
	input wire logic core_clk,
	input wire logic rst,
	input wire fast_detect_pkg::sample_in_t sampleIn,
	input wire fast_detect_pkg::thresholds_t thresholds,
	output fast_detect_pkg::chan_flags_t flags
);

	logic [3:0] coarseEarly;
	logic [3:0] coarseLate;
	logic [13:0] absValue;
	logic [12:0] magnitude;

	// the output flop in the top adds the last cycle of each latency
	delay_line #(.WIDTH(4), .DEPTH(`FAST_LATENCY - 1)) earlyDelay (
		.core_clk(core_clk),
		.rst(rst),
		.din(sampleIn.coarseLevel),
		.dout(coarseEarly)
	);

	delay_line #(.WIDTH(4), .DEPTH(`SUBSET_LATENCY - 1)) lateDelay (
		.core_clk(core_clk),
		.rst(rst),
		.din(sampleIn.coarseLevel),
		.dout(coarseLate)
	);

	always_comb
	begin
		// sign is dropped so both excursions compare alike
		absValue = sampleIn.sample[13] ? 14'((~sampleIn.sample) + 14'h0001) : sampleIn.sample;
		// full scale gives 8192, which does not fit 13 bits
		magnitude = absValue[13] ? `MAG_MAX : absValue[12:0];
		flags.mag4 = coarseEarly;
		// code 1000 folds into 111 so the top code spans up to full scale
		flags.mag3 = (coarseLate > `COARSE_SUBSET_MAX) ? 3'h7 : coarseLate[2:0];
		// overflow judged on the full pipelined word
		flags.overrangeFlag = sampleIn.pipeOverflow;
		// stays low while the magnitude is at or under the threshold
		flags.fineUpperFlag = magnitude > thresholds.upper;
		flags.fineLowerFlag = magnitude < thresholds.lower;
	end

endmodule : fast_detect_channel

// File: src/fast_overrange_detect.sv
`include "fast_detect_defs.svh"

module fast_overrange_detect (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] regChanSel,
	input wire logic regWrite,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire fast_detect_pkg::sample_in_t chanAIn,
	input wire fast_detect_pkg::sample_in_t chanBIn,
	output logic [3:0] fastLevelBitsA,
	output logic [3:0] fastLevelBitsB,
	output logic fastLevelOeA,
	output logic fastLevelOeB,
	output logic dataOeA,
	output logic dataOeB
);

	localparam int NCHAN = 2;

	// per-channel configuration, one copy per channel
	fast_detect_pkg::fd_mode_t fdMode [NCHAN];
	fast_detect_pkg::fd_mode_t next_fdMode [NCHAN];
	fast_detect_pkg::thresholds_t thresh [NCHAN];
	fast_detect_pkg::thresholds_t next_thresh [NCHAN];
	logic outputDisable [NCHAN];
	logic next_outputDisable [NCHAN];
	logic [7:0] next_regRdata;

	fast_detect_pkg::sample_in_t chanIn [NCHAN];
	fast_detect_pkg::chan_flags_t flags [NCHAN];
	logic [3:0] fastBits [NCHAN];
	logic [3:0] next_fastBits [NCHAN];
	logic fastOe [NCHAN];
	logic next_fastOe [NCHAN];

	// read side looks at channel A unless only B is selected
	logic readChan;

	assign chanIn[0] = chanAIn;
	assign chanIn[1] = chanBIn;

	// arranges the four pins for one channel from its flags
	function automatic logic [3:0] arrangeBits(
		input fast_detect_pkg::fd_mode_t mode,
		input fast_detect_pkg::chan_flags_t f
	);
		logic [3:0] bits;
		bits = 4'h0;
		case (mode)
			fast_detect_pkg::MODE_MAG4:
			begin
				// early coarse level, codes 0000..1000 pass through unchanged
				bits = f.mag4;
			end
			fast_detect_pkg::MODE_MAG3_OVR:
			begin
				bits = {f.mag3, f.overrangeFlag};
			end
			fast_detect_pkg::MODE_MAG2_OVR_LOWER:
			begin
				// the subset drops the least significant coarse bit
				bits = {f.mag3[2:1], f.overrangeFlag, f.fineLowerFlag};
			end
			fast_detect_pkg::MODE_MAG2_LOWER:
			begin
				bits = {f.mag3[2:1], 1'b0, f.fineLowerFlag};
			end
			fast_detect_pkg::MODE_OVR_UPPER_LOWER:
			begin
				bits = {f.overrangeFlag, 1'b0, f.fineUpperFlag, f.fineLowerFlag};
			end
			fast_detect_pkg::MODE_OVR_UPPER:
			begin
				bits = {f.overrangeFlag, f.fineUpperFlag, 2'h0};
			end
			default:
			begin
				// spare codes keep the pins quiet rather than guess a layout
				bits = 4'h0;
			end
		endcase
		return bits;
	endfunction : arrangeBits

	// timing of one channel, counted in sample clock edges:
	// - the coarse level passes a short delay line for the full-level mode
	//   and a longer one for the subset modes
	// - sample magnitude and the fine compares are combinational
	// - the pin stage adds the final edge to every path
	// the overrange flag is taken as delivered by the converter pipeline;
	// it is not recomputed here from the sample word, which keeps the
	// traditional overflow definition in one place
	// limitation: the fine flags follow the sample with one edge of delay
	// only; any extra latency belongs to the pipeline upstream
	generate
		for (genvar ch = 0; ch < NCHAN; ch++)
		begin : chanGen
			// each channel has its own detect path
			fast_detect_channel detect (
				.core_clk(core_clk),
				.rst(rst),
				.sampleIn(chanIn[ch]),
				.thresholds(thresh[ch]),
				.flags(flags[ch])
			);
		end
	endgenerate

	// register writes; a write lands in every channel whose select bit is set
	always_comb
	begin
		for (int ch = 0; ch < NCHAN; ch++)
		begin
			next_fdMode[ch] = fdMode[ch];
			next_thresh[ch] = thresh[ch];
			next_outputDisable[ch] = outputDisable[ch];
			if (regWrite && regChanSel[ch])
			begin
				case (regAddr)
					`ADDR_FD_CONTROL:
					begin
						next_fdMode[ch] = fast_detect_pkg::fd_mode_t'(
							regWdata[`FD_MODE_MSB:`FD_MODE_LSB]);
					end
					`ADDR_UPPER_LOW:
					begin
						next_thresh[ch].upper[7:0] = regWdata;
					end
					`ADDR_UPPER_HIGH:
					begin
						next_thresh[ch].upper[12:8] = regWdata[`THRESH_HIGH_BITS-1:0];
					end
					`ADDR_LOWER_LOW:
					begin
						next_thresh[ch].lower[7:0] = regWdata;
					end
					`ADDR_LOWER_HIGH:
					begin
						next_thresh[ch].lower[12:8] = regWdata[`THRESH_HIGH_BITS-1:0];
					end
					`ADDR_OUTPUT_MODE:
					begin
						next_outputDisable[ch] = regWdata[`OUTPUT_DISABLE_BIT];
					end
					default:
					begin
						next_outputDisable[ch] = outputDisable[ch];
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		for (int ch = 0; ch < NCHAN; ch++)
		begin
			if (rst)
			begin
				fdMode[ch] <= fast_detect_pkg::fd_mode_t'(`FD_MODE_RESET);
				thresh[ch].upper <= `UPPER_RESET;
				thresh[ch].lower <= `LOWER_RESET;
				outputDisable[ch] <= `OUTPUT_DISABLE_RESET;
			end
			else
			begin
				fdMode[ch] <= next_fdMode[ch];
				thresh[ch] <= next_thresh[ch];
				outputDisable[ch] <= next_outputDisable[ch];
			end
		end
	end

	// only one channel is read back at a time; selecting both reads channel A,
	// so a broadcast write can be read back without changing the select
	// readback, one cycle behind the address; unmapped addresses read zero
	always_comb
	begin
		readChan = (regChanSel == 2'h2);
		next_regRdata = 8'h00;
		case (regAddr)
			`ADDR_FD_CONTROL:
			begin
				next_regRdata[`FD_MODE_MSB:`FD_MODE_LSB] = fdMode[readChan];
			end
			`ADDR_UPPER_LOW:
			begin
				next_regRdata = thresh[readChan].upper[7:0];
			end
			`ADDR_UPPER_HIGH:
			begin
				next_regRdata[`THRESH_HIGH_BITS-1:0] = thresh[readChan].upper[12:8];
			end
			`ADDR_LOWER_LOW:
			begin
				next_regRdata = thresh[readChan].lower[7:0];
			end
			`ADDR_LOWER_HIGH:
			begin
				next_regRdata[`THRESH_HIGH_BITS-1:0] = thresh[readChan].lower[12:8];
			end
			`ADDR_OUTPUT_MODE:
			begin
				next_regRdata[`OUTPUT_DISABLE_BIT] = outputDisable[readChan];
			end
			default:
			begin
				next_regRdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			regRdata <= 8'h00;
		else
			regRdata <= next_regRdata;
	end

	// pin stage; this flop is the last cycle of every latency figure
	always_comb
	begin
		for (int ch = 0; ch < NCHAN; ch++)
		begin
			next_fastBits[ch] = arrangeBits(fdMode[ch], flags[ch]);
			// a disabled channel floats both its data and its level pins
			next_fastOe[ch] = !outputDisable[ch];
		end
	end

	always_ff @(posedge core_clk)
	begin
		for (int ch = 0; ch < NCHAN; ch++)
		begin
			if (rst)
			begin
				fastBits[ch] <= 4'h0;
				fastOe[ch] <= 1'b0;
			end
			else
			begin
				fastBits[ch] <= next_fastBits[ch];
				fastOe[ch] <= next_fastOe[ch];
			end
		end
	end

	// level pins come straight from the pin-stage flops above
	assign fastLevelBitsA = fastBits[0];
	assign fastLevelBitsB = fastBits[1];
	assign fastLevelOeA = fastOe[0];
	assign fastLevelOeB = fastOe[1];

	// data enables mirror the level enables but stay separate flops, so the
	// data block can be given its own enable later without touching the pins
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dataOeA <= 1'b0;
			dataOeB <= 1'b0;
		end
		else
		begin
			dataOeA <= next_fastOe[0];
			dataOeB <= next_fastOe[1];
		end
	end

endmodule : fast_overrange_detect

// File: verif/fast_overrange_detect_props.sv
`include "fast_detect_defs.svh"

module fast_overrange_detect_props (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] regChanSel,
	input wire logic regWrite,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire fast_detect_pkg::sample_in_t chanAIn,
	input wire logic [3:0] fastLevelBitsA,
	input wire logic fastLevelOeA,
	input wire logic dataOeA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] modeA;
	logic [2:0] next_modeA;
	logic [2:0] clampA;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// shadow of channel A mode, updated on the same edge as the real register
	always_comb
	begin
		next_modeA = modeA;
		if (regWrite && regAddr == `ADDR_FD_CONTROL && regChanSel[0])
			next_modeA = regWdata[3:1];
		if (rst)
			next_modeA = 3'h0;
	end
	always_ff @(posedge core_clk)
		modeA <= next_modeA;
	assign clampA = chanAIn.coarseLevel[3] ? 3'h7 : chanAIn.coarseLevel[2:0];
	rdata_latency_a: assert property (
		regWrite && regAddr == `ADDR_UPPER_LOW && regChanSel[0] ##1 regAddr == `ADDR_UPPER_LOW
		|=> regRdata == $past(regWdata, 2)) else $error("threshold readback wrong");
	unmapped_read_a: assert property (regAddr == 13'h0000 |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_unused_a: assert property (
		regAddr == `ADDR_FD_CONTROL |=> regRdata[7:4] == 4'h0 && !regRdata[0])
		else $error("mode register spare bits set");
	oe_disable_a: assert property (
		regWrite && regAddr == `ADDR_OUTPUT_MODE && regChanSel[0]
		|=> ##1 fastLevelOeA == !$past(regWdata[4], 2)) else $error("level enable wrong");
	data_oe_a: assert property (dataOeA == fastLevelOeA)
		else $error("data enable differs");
	spare_low_a: assert property (modeA >= 3'h6 |=> fastLevelBitsA == 4'h0)
		else $error("spare mode bits not low");
	mag4_lat_a: assert property (
		modeA == 3'h0 |=> fastLevelBitsA == $past(chanAIn.coarseLevel, 2))
		else $error("coarse level latency wrong");
	mag3_lat_a: assert property (
		modeA == 3'h1 |=> fastLevelBitsA == {$past(clampA, 6), $past(chanAIn.pipeOverflow)})
		else $error("subset latency wrong");
	ovr_upper_a: assert property (
		modeA == 3'h4 |=> fastLevelBitsA[3] == $past(chanAIn.pipeOverflow)
		&& !fastLevelBitsA[2]) else $error("overrange arrangement wrong");
endmodule : fast_overrange_detect_props

bind fast_overrange_detect fast_overrange_detect_props checker_i (
	.core_clk(core_clk),
	.rst(rst),
	.regChanSel(regChanSel),
	.regWrite(regWrite),
	.regAddr(regAddr),
	.regWdata(regWdata),
	.regRdata(regRdata),
	.chanAIn(chanAIn),
	.fastLevelBitsA(fastLevelBitsA),
	.fastLevelOeA(fastLevelOeA),
	.dataOeA(dataOeA)
);

// File: verif/gain_ctrl_model.sv
module gain_ctrl_model (
	input wire logic core_clk,
	input wire logic [3:0] fastLevelBits,
	input wire logic fastLevelOe,
	output logic attenuate
);
	timeunit 1ns;
	timeprecision 1ps;
	// upper flag sits on bit 1 in mode 100; a floated pin must not trip the attenuator
	always_ff @(posedge core_clk)
		attenuate <= fastLevelOe && fastLevelBits[1];
endmodule : gain_ctrl_model

// File: verif/test_fast_overrange_detect.sv
`include "fast_detect_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module test_fast_overrange_detect;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] regChanSel = 2'h0;
	logic regWrite = 1'b0;
	logic [`ADDR_W-1:0] regAddr = 13'h0000;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	fast_detect_pkg::sample_in_t chanAIn = '0;
	fast_detect_pkg::sample_in_t chanBIn = '0;
	logic [3:0] fastLevelBitsA;
	logic [3:0] fastLevelBitsB;
	logic fastLevelOeA;
	logic fastLevelOeB;
	logic dataOeA;
	logic dataOeB;
	logic attenuate;
	int n_fail = 0;
	int num_checks = 0;

	always #25 core_clk = ~core_clk;

	fast_overrange_detect DUT (.core_clk(core_clk), .rst(rst), .regChanSel(regChanSel),
		.regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.chanAIn(chanAIn), .chanBIn(chanBIn), .fastLevelBitsA(fastLevelBitsA),
		.fastLevelBitsB(fastLevelBitsB), .fastLevelOeA(fastLevelOeA),
		.fastLevelOeB(fastLevelOeB), .dataOeA(dataOeA), .dataOeB(dataOeB));
	gain_ctrl_model farSide (.core_clk(core_clk), .fastLevelBits(fastLevelBitsA),
		.fastLevelOe(fastLevelOeA), .attenuate(attenuate));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [1:0] sel, input logic [12:0] addr, input logic [7:0] data);
		@(negedge core_clk);
		regChanSel = sel;
		regAddr = addr;
		regWdata = data;
		regWrite = 1'b1;
		@(negedge core_clk);
		regWrite = 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] sel, input logic [12:0] addr, input logic [7:0] exp);
		@(negedge core_clk);
		regChanSel = sel;
		regAddr = addr;
		@(negedge core_clk);
		`CHK("regRdata", exp, regRdata)
	endtask : rd

	// channel B sees the negated sample, so both must agree on magnitude
	task automatic lvl(input logic [2:0] mode, input logic [3:0] c, input logic [13:0] s,
		input logic overrange_flag, input logic [3:0] exp);
		wr(2'h3, `ADDR_FD_CONTROL, {4'h0, mode, 1'b0});
		chanAIn = '{c, s, overrange_flag};
		chanBIn = '{c, -s, overrange_flag};
		repeat (8) @(negedge core_clk);
		`CHK("fastLevelBitsA", exp, fastLevelBitsA)
		`CHK("fastLevelBitsB", exp, fastLevelBitsB)
	endtask : lvl

	initial
	begin
		#200us;
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK("fastLevelOeA", 1'b1, fastLevelOeA)
		`CHK("dataOeA", 1'b1, dataOeA)
		`CHK("dataOeB", 1'b1, dataOeB)
		rd(2'h1, `ADDR_FD_CONTROL, 8'h00);
		rd(2'h1, `ADDR_UPPER_LOW, 8'hFF);
		rd(2'h2, `ADDR_UPPER_HIGH, 8'h1F);
		rd(2'h1, `ADDR_LOWER_HIGH, 8'h00);
		rd(2'h1, 13'h0000, 8'h00);
		wr(2'h1, `ADDR_UPPER_HIGH, 8'hFF);
		rd(2'h1, `ADDR_UPPER_HIGH, 8'h1F);
		wr(2'h3, `ADDR_UPPER_LOW, 8'h64);
		wr(2'h3, `ADDR_UPPER_HIGH, 8'h00);
		rd(2'h1, `ADDR_UPPER_LOW, 8'h64);
		wr(2'h3, `ADDR_LOWER_LOW, 8'h32);
		for (int i = 0; i < 9; i++)
			lvl(3'h0, 4'(i), 14'h0000, 1'b0, 4'(i));
		lvl(3'h1, 4'h8, 14'h0000, 1'b1, 4'hF);
		lvl(3'h1, 4'h5, 14'h0000, 1'b0, 4'hA);
		lvl(3'h2, 4'h6, 14'h001E, 1'b1, 4'hF);
		lvl(3'h2, 4'h3, 14'h00C8, 1'b0, 4'h4);
		lvl(3'h3, 4'h8, 14'h001E, 1'b1, 4'hD);
		lvl(3'h4, 4'h0, 14'h00C8, 1'b0, 4'h2);
		`CHK("attenuate", 1'b1, attenuate)
		lvl(3'h4, 4'h0, 14'h0032, 1'b1, 4'h8);
		lvl(3'h4, 4'h0, 14'h0031, 1'b0, 4'h1);
		lvl(3'h4, 4'h0, 14'h0064, 1'b0, 4'h0);
		lvl(3'h5, 4'h0, 14'h00C8, 1'b1, 4'hC);
		wr(2'h3, `ADDR_UPPER_LOW, 8'hFE);
		wr(2'h3, `ADDR_UPPER_HIGH, 8'h1F);
		lvl(3'h5, 4'h0, 14'h2000, 1'b0, 4'h4);
		lvl(3'h6, 4'h8, 14'h00C8, 1'b1, 4'h0);
		lvl(3'h7, 4'h8, 14'h00C8, 1'b1, 4'h0);
		wr(2'h1, `ADDR_OUTPUT_MODE, 8'h10);
		repeat (3) @(negedge core_clk);
		`CHK("fastLevelOeA", 1'b0, fastLevelOeA)
		`CHK("fastLevelOeB", 1'b1, fastLevelOeB)
		`CHK("dataOeA", 1'b0, dataOeA)
		`CHK("dataOeB", 1'b1, dataOeB)
		tally_and_finish();
	end
endmodule : test_fast_overrange_detect
